// file: rtl/swd_watchdog.sv
// swd_watchdog: system watchdog timer with AXI4-Lite register slave
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// RULE_01: watchdog is a binary up-counter stepped by every system clock.
// RULE_02: three-bit period field selects one of six power-of-two timeouts.
// RULE_03: codes 0..5 give 2^15..2^25 cycles; codes 6 and 7 reserved.
// RULE_04: timeout raises the watchdog interrupt and pulls the timeout pin low.
// RULE_05: software clears the counter before every timeout elapses.
// RULE_06: counting starts at reset release; unused watchdog must be disabled.
// RULE_07: software disables the watchdog before deep stop mode.
// RULE_08: counter freezes while the processor is halted in debug.
// RULE_09: action bit 0: overflow raises the non-maskable interrupt and lowers pin.
// RULE_10: clear code 0x4E returns the timeout pin high.
// RULE_11: action bit 1: overflow resets the chip for 32 states.
// RULE_12: software checks write-status zero before writing mode or code.
// RULE_13: write-status reads 0 when writes accepted, 1 when not.
// RULE_14: disable code write may directly follow the mode write.
// RULE_15: 0xB1 with enable 0 stops and clears; enable 1 restarts.
// RULE_16: clear code zeroes the counter and counting resumes.
// RULE_17: other code values change neither counter nor enable.
module swd_watchdog (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// axi4-lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// debug halt from the processor, asynchronous
	input wire logic debugHalt,
	// watchdog outputs
	output logic timeout_interrupt,
	output logic timeout_out_n,
	output logic wdtResetReq
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [11:0] awAddr;
		logic awHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic wHave;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic [7:0] mode;
		logic running;
		logic [1:0] busyCnt;
		logic disPending;
		swd_pkg::swd_state_t st;
		logic [5:0] rstCnt;
		logic irq;
		logic pinLow;
	} swd_watchdog_t;
	swd_watchdog_t s_q;
	swd_watchdog_t s_d;

	logic haltSync;
	logic [swd_pkg::CNT_W-1:0] count;
	logic overflow;
	logic cntRun;
	logic cntClear;
	logic wrFire;
	logic [11:0] wrAddr;
	logic [7:0] codeByte;
	logic isClear;
	logic isDisable;
	logic modeWr;
	logic codeWr;
	logic [7:0] newMode;

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	// debug halt comes from another domain, two flops before use
	swd_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.din(debugHalt),
		.dout(haltSync)
	);

	swd_counter u_cnt (
		.clk(clk),
		.rst_b(rst_b),
		.run(cntRun),
		.clear(cntClear),
		.periodSel(s_q.mode[swd_pkg::PERIOD_MSB:swd_pkg::PERIOD_LSB]),
		.count(count),
		.overflow(overflow)
	);

	// ---------------------------------------------------------------
	// write decode
	// ---------------------------------------------------------------
	// a write fires once both address and data are held and no response waits
	always_comb begin
		wrFire = s_q.awHave && s_q.wHave && !s_q.bValid;
		wrAddr = {s_q.awAddr[swd_pkg::ADDR_MSB:swd_pkg::ADDR_LSB], 2'h0};
		codeByte = s_q.wData[7:0];
		// busy drops writes; a code write right after a mode write that clears enable stays allowed
		modeWr = wrFire && s_q.wStrb[0] && (wrAddr == swd_pkg::MODE_OFFSET) && (s_q.busyCnt == '0); // RULE_13
		codeWr = wrFire && s_q.wStrb[0] && (wrAddr == swd_pkg::CODE_OFFSET)
			&& ((s_q.busyCnt == '0) || s_q.disPending); // RULE_14
		isClear = codeWr && (codeByte == swd_pkg::CODE_CLEAR);
		isDisable = codeWr && (codeByte == swd_pkg::CODE_DISABLE) && !s_q.mode[swd_pkg::ENABLE_BIT];
		newMode = (s_q.mode & ~swd_pkg::MODE_WMASK) | (codeByte & swd_pkg::MODE_WMASK);
	end

	// counter steps when running, not halted and not in reset action
	// a cleared enable bit alone does not stop it, so one stray write cannot kill the watchdog
	always_comb begin
		cntRun = s_q.running && !haltSync && (s_q.st != swd_pkg::SWD_RESET); // RULE_08
		cntClear = isClear || isDisable; // RULE_16
	end

	// ---------------------------------------------------------------
	// main next-state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// write address and data captured independently
		if (s_axi_awvalid && !s_q.awHave) begin
			s_d.awHave = 1'b1;
			s_d.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.wHave) begin
			s_d.wHave = 1'b1;
			s_d.wData = s_axi_wdata;
			s_d.wStrb = s_axi_wstrb;
		end
		if (s_q.bValid && s_axi_bready) begin
			s_d.bValid = 1'b0;
		end
		if (s_q.busyCnt != '0) begin
			s_d.busyCnt = s_q.busyCnt - 2'h1;
		end
		if (wrFire) begin
			s_d.awHave = 1'b0;
			s_d.wHave = 1'b0;
			s_d.bValid = 1'b1;
			s_d.bResp = swd_pkg::RESP_OKAY;
			s_d.disPending = 1'b0;
			if (wrAddr > swd_pkg::COUNT_OFFSET) begin
				s_d.bResp = swd_pkg::RESP_SLVERR;
			end
			if (modeWr) begin
				s_d.mode = newMode; // RULE_15
				s_d.busyCnt = swd_pkg::BUSY_LOAD;
				s_d.disPending = !newMode[swd_pkg::ENABLE_BIT];
				// setting the enable bit restarts at once; clearing it only arms the disable code
				if (newMode[swd_pkg::ENABLE_BIT]) begin
					s_d.running = 1'b1; // RULE_15
				end
			end
			if (isDisable) begin
				s_d.running = 1'b0; // RULE_15
			end
			// only the two codes take effect; other values leave busy, counter and enable alone
			if (isClear || isDisable) begin
				s_d.busyCnt = swd_pkg::BUSY_LOAD; // RULE_17
			end
		end
		// read channel
		if (s_q.rValid && s_axi_rready) begin
			s_d.rValid = 1'b0;
		end
		if (s_axi_arvalid && !s_q.rValid) begin
			s_d.rValid = 1'b1;
			s_d.rResp = swd_pkg::RESP_OKAY;
			s_d.rData = '0;
			case ({s_axi_araddr[swd_pkg::ADDR_MSB:swd_pkg::ADDR_LSB], 2'h0})
				swd_pkg::MODE_OFFSET: s_d.rData[7:0] = s_q.mode;
				swd_pkg::CODE_OFFSET: s_d.rData = '0;
				swd_pkg::STATUS_OFFSET: s_d.rData[0] = (s_q.busyCnt != '0); // RULE_13
				swd_pkg::COUNT_OFFSET: s_d.rData[swd_pkg::CNT_W-1:0] = count;
				default: s_d.rResp = swd_pkg::RESP_SLVERR;
			endcase
		end
		// overflow action, clear code releases the pin
		case (s_q.st)
			swd_pkg::SWD_RUN: begin
				if (overflow && s_q.mode[swd_pkg::ACTION_BIT]) begin
					s_d.st = swd_pkg::SWD_RESET; // RULE_11
					s_d.rstCnt = swd_pkg::RESET_HOLD;
				end else if (overflow) begin
					s_d.st = swd_pkg::SWD_FIRED;
					s_d.irq = 1'b1; // RULE_09
					s_d.pinLow = 1'b1; // RULE_04
				end
			end
			swd_pkg::SWD_FIRED: begin
				s_d.irq = 1'b0;
				if (isClear || isDisable) begin
					s_d.st = swd_pkg::SWD_RUN;
					s_d.pinLow = 1'b0; // RULE_10
				end
			end
			swd_pkg::SWD_RESET: begin
				s_d.rstCnt = s_q.rstCnt - 6'h1;
				if (s_q.rstCnt == 6'h1) begin
					// chip reset is expected to reset us too; fall back to defaults
					s_d.st = swd_pkg::SWD_RUN;
					s_d.mode = swd_pkg::MODE_RESET;
					s_d.running = 1'b1;
				end
			end
			default: s_d.st = swd_pkg::SWD_RUN;
		endcase
		// a clear in the same cycle as a new overflow cannot be lost: counter clear precludes it
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// mode resets enabled so counting begins at release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.mode <= swd_pkg::MODE_RESET; // RULE_06
			s_q.running <= 1'b1;
			s_q.st <= swd_pkg::SWD_RUN;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign s_axi_awready = !s_q.awHave;
	assign s_axi_wready = !s_q.wHave;
	assign s_axi_bvalid = s_q.bValid;
	assign s_axi_bresp = s_q.bResp;
	assign s_axi_arready = !s_q.rValid;
	assign s_axi_rvalid = s_q.rValid;
	assign s_axi_rdata = s_q.rData;
	assign s_axi_rresp = s_q.rResp;
	assign timeout_interrupt = s_q.irq;
	assign timeout_out_n = !s_q.pinLow;
	assign wdtResetReq = (s_q.st == swd_pkg::SWD_RESET); // RULE_11

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence seqIrqOverflow;
		overflow && !s_q.mode[swd_pkg::ACTION_BIT] && (s_q.st == swd_pkg::SWD_RUN);
	endsequence

	a_irq_on_timeout: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		seqIrqOverflow |=> timeout_interrupt && !timeout_out_n)
		else $error("timeout did not raise interrupt and pin");
	a_irq_one_pulse: assert property (@(posedge clk) disable iff (!rst_b) // RULE_09
		timeout_interrupt |=> !timeout_interrupt)
		else $error("interrupt longer than one cycle");
	a_pin_release: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
		(s_q.st == swd_pkg::SWD_FIRED) && isClear |=> timeout_out_n)
		else $error("clear code did not release pin");
	a_reset_length: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		$rose(wdtResetReq) |-> wdtResetReq [*8] ##0 (s_q.rstCnt == 6'd25))
		else $error("reset hold count wrong");
	a_clear_zero: assert property (@(posedge clk) disable iff (!rst_b) // RULE_16
		isClear |=> count == '0)
		else $error("clear code did not zero counter");
	a_disable_stop: assert property (@(posedge clk) disable iff (!rst_b) // RULE_15
		isDisable && !modeWr |=> count == '0 ##1 count == '0)
		else $error("disable code did not stop counter");
	a_debug_freeze: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
		haltSync && !cntClear |=> $stable(count))
		else $error("counter moved in debug halt");
	a_count_step: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		cntRun && !cntClear && !overflow |=> count == $past(count) + 1'b1)
		else $error("counter did not step");
	a_busy_flag: assert property (@(posedge clk) disable iff (!rst_b) // RULE_13
		modeWr |=> s_q.busyCnt != '0)
		else $error("write status not busy after mode write");
	a_other_code: assert property (@(posedge clk) disable iff (!rst_b) // RULE_17
		codeWr && !isClear && !isDisable && !modeWr |=> $stable(s_q.mode))
		else $error("reserved code changed enable");

	// reset action path
	sequence seqResetOverflow;
		overflow && s_q.mode[swd_pkg::ACTION_BIT] && (s_q.st == swd_pkg::SWD_RUN);
	endsequence

	sequence seqResetLast;
		(s_q.st == swd_pkg::SWD_RESET) && (s_q.rstCnt == 6'h1);
	endsequence

	a_reset_entry: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		seqResetOverflow |=> wdtResetReq && !timeout_interrupt && timeout_out_n)
		else $error("overflow in reset mode did not start reset");
	a_reset_exit: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		seqResetLast |=> !wdtResetReq && s_q.running && (s_q.mode == swd_pkg::MODE_RESET))
		else $error("reset action did not end with defaults");

	// interrupt and pin path
	a_irq_pin_low: assert property (@(posedge clk) disable iff (!rst_b) // RULE_09
		timeout_interrupt |-> !timeout_out_n && !wdtResetReq)
		else $error("interrupt without low pin");
	a_pin_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		!timeout_out_n && !isClear && !isDisable |=> !timeout_out_n)
		else $error("pin released without clear");

	// counter control
	a_period_wrap: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		overflow |=> count == '0)
		else $error("counter did not wrap at period");
	a_stopped_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE_15
		!s_q.running && !cntClear |=> $stable(count))
		else $error("stopped counter moved");
	a_mode_keeps_run: assert property (@(posedge clk) disable iff (!rst_b) // RULE_15
		modeWr && !newMode[swd_pkg::ENABLE_BIT] && s_q.running |=> s_q.running)
		else $error("enable bit alone stopped the watchdog");

	// register access while busy
	a_busy_drop: assert property (@(posedge clk) disable iff (!rst_b) // RULE_13
		wrFire && (wrAddr == swd_pkg::MODE_OFFSET) && (s_q.busyCnt != '0) && (s_q.st != swd_pkg::SWD_RESET)
		|=> $stable(s_q.mode))
		else $error("mode written while busy");
	a_code_busy: assert property (@(posedge clk) disable iff (!rst_b) // RULE_14
		wrFire && (wrAddr == swd_pkg::CODE_OFFSET) && (s_q.busyCnt != '0) && !s_q.disPending |-> !cntClear)
		else $error("code taken while busy");
endmodule : swd_watchdog

// file: rtl/swd_pkg.sv
// swd_pkg: register map, codes and timing constants of the system watchdog
package swd_pkg;
	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] MODE_OFFSET = 12'h000;
	localparam logic [11:0] CODE_OFFSET = 12'h004;
	localparam logic [11:0] STATUS_OFFSET = 12'h008;
	localparam logic [11:0] COUNT_OFFSET = 12'h00C;
	localparam int ADDR_MSB = 11;
	localparam int ADDR_LSB = 2;
	// ---------------------------------------------------------------
	// mode register fields
	// ---------------------------------------------------------------
	localparam int ENABLE_BIT = 7;
	localparam int PERIOD_MSB = 6;
	localparam int PERIOD_LSB = 4;
	localparam int RSVD_BIT = 2;
	localparam int ACTION_BIT = 1;
	localparam logic [7:0] MODE_RESET = 8'h82;
	localparam logic [7:0] MODE_WMASK = 8'hF6;
	// ---------------------------------------------------------------
	// control codes
	// ---------------------------------------------------------------
	localparam logic [7:0] CODE_DISABLE = 8'hB1;
	localparam logic [7:0] CODE_CLEAR = 8'h4E;
	// ---------------------------------------------------------------
	// counter and timing
	// ---------------------------------------------------------------
	localparam int CNT_W = 25;
	localparam logic [2:0] PERIOD_MAX = 3'h5;
	localparam int PERIOD_LOG2_MIN = 15;
	localparam int PERIOD_LOG2_STEP = 2;
	localparam int RESET_STATES = 32;
	localparam logic [5:0] RESET_HOLD = 6'(RESET_STATES);
	localparam int BUSY_CYCLES = 2;
	localparam logic [1:0] BUSY_LOAD = 2'(BUSY_CYCLES);
	// ---------------------------------------------------------------
	// bus response codes
	// ---------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// watchdog action state
	typedef enum logic [1:0] {
		SWD_RUN = 2'h0,
		SWD_FIRED = 2'h1,
		SWD_RESET = 2'h3
	} swd_state_t;
endpackage : swd_pkg

// file: rtl/swd_sync.sv
// swd_sync: two-flop synchroniser for the debug halt level
`timescale 1ns/10ps
module swd_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// level in and out
	input wire logic din,
	output logic dout
);
	typedef struct packed {
		logic stage1;
		logic stage2;
	} swd_sync_t;
	swd_sync_t s_q;
	swd_sync_t s_d;

	// first stage feeds only the second
	always_comb begin
		s_d.stage1 = din;
		s_d.stage2 = s_q.stage1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.stage2;
endmodule : swd_sync

// file: rtl/swd_counter.sv
// swd_counter: binary up-counter with clear and freeze, overflow pulse per period
`timescale 1ns/10ps
module swd_counter (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic run,
	input wire logic clear,
	input wire logic [2:0] periodSel,
	// status
	output logic [swd_pkg::CNT_W-1:0] count,
	output logic overflow
);
	typedef struct packed {
		logic [swd_pkg::CNT_W-1:0] cnt;
	} swd_counter_t;
	swd_counter_t c_q;
	swd_counter_t c_d;
	logic [swd_pkg::CNT_W-1:0] lastVal;
	logic [4:0] log2Len;

	// terminal count for 2^(15+2k) cycles, reserved codes use the longest
	always_comb begin
		if (periodSel > swd_pkg::PERIOD_MAX) begin
			log2Len = 5'(swd_pkg::CNT_W); // RULE_03
		end else begin
			log2Len = 5'(swd_pkg::PERIOD_LOG2_MIN + swd_pkg::PERIOD_LOG2_STEP * int'(periodSel)); // RULE_03
		end
		lastVal = ~({swd_pkg::CNT_W{1'b1}} << log2Len);
	end

	// clear wins over counting; wrap at the selected period
	always_comb begin
		c_d = c_q;
		if (clear) begin
			c_d.cnt = '0;
		end else if (run) begin
			if (c_q.cnt >= lastVal) begin
				c_d.cnt = '0;
			end else begin
				c_d.cnt = c_q.cnt + 1'b1; // RULE_01
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	assign count = c_q.cnt;
	assign overflow = run && !clear && (c_q.cnt >= lastVal); // RULE_02
endmodule : swd_counter

// file: dv/tb_swd_watchdog.sv
// tb_swd_watchdog: self-checking bench of the system watchdog over its AXI4-Lite slave
`timescale 1ns/10ps
module tb_swd_watchdog;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk, rst_b, debugHalt;
	logic [11:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic irq, pinN, rstReq;
	int fails, cmp_count;

	swd_watchdog dut (
		.clk(clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.debugHalt(debugHalt),
		.timeout_interrupt(irq), .timeout_out_n(pinN), .wdtResetReq(rstReq)
	);

	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	// every handshake is judged at the rising edge where it happens, then released by nba
	task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rsp);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(posedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bready && bvalid;
			rsp = bresp;
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end
	endtask : axiWrite

	task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rsp);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(posedge clk);
			ta = arvalid && arready;
			tr = rready && rvalid;
			d = rdata;
			rsp = rresp;
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end
	endtask : axiRead

	task automatic rdCount(output logic [31:0] v);
		logic [1:0] r;
		axiRead(swd_pkg::COUNT_OFFSET, v, r);
	endtask : rdCount

	// poll the busy flag before every guarded write
	task automatic wrGuarded(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic [1:0] r;
		do axiRead(swd_pkg::STATUS_OFFSET, v, r); while (v[0] !== 1'b0);
		axiWrite(a, d, r);
	endtask : wrGuarded

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic tReset();
		logic [31:0] v;
		logic [1:0] r;
		chk("pin idle", 32'(pinN), 32'h1);
		chk("reset request idle", 32'(rstReq), 32'h0);
		axiRead(swd_pkg::MODE_OFFSET, v, r);
		chk("mode reset value", v, 32'(swd_pkg::MODE_RESET));
		chk("mode resp", 32'(r), 32'(swd_pkg::RESP_OKAY));
		axiRead(swd_pkg::STATUS_OFFSET, v, r);
		chk("status idle", v, 32'h0);
		axiRead(swd_pkg::CODE_OFFSET, v, r);
		chk("code reads zero", v, 32'h0);
		axiRead(12'h010, v, r);
		chk("unmapped read resp", 32'(r), 32'(swd_pkg::RESP_SLVERR));
		axiWrite(12'h010, 32'h0, r);
		chk("unmapped write resp", 32'(r), 32'(swd_pkg::RESP_SLVERR));
	endtask : tReset

	// status read issued while a mode write has just landed must report busy
	task automatic tBusyFlag();
		logic [31:0] v;
		logic [1:0] r, r2;
		do axiRead(swd_pkg::STATUS_OFFSET, v, r); while (v[0] !== 1'b0);
		fork
			axiWrite(swd_pkg::MODE_OFFSET, 32'h80, r);
			begin
				repeat (2) @(posedge clk);
				axiRead(swd_pkg::STATUS_OFFSET, v, r2);
			end
		join
		chk("status busy after mode write", v, 32'h1);
	endtask : tBusyFlag

	// every period code incl. reserved; bits 0 and 3 must read back as zero
	task automatic tModes();
		logic [31:0] v;
		logic [1:0] r;
		for (int p = 0; p < 8; p++) begin
			wrGuarded(swd_pkg::MODE_OFFSET, 32'h8F | 32'(p << 4));
			axiRead(swd_pkg::MODE_OFFSET, v, r);
			chk("mode period field", v, 32'h86 | 32'(p << 4));
		end
		wrGuarded(swd_pkg::MODE_OFFSET, 32'h80);
	endtask : tModes

	task automatic tRuns();
		logic [31:0] c1, c2;
		rdCount(c1);
		repeat (20) @(posedge clk);
		rdCount(c2);
		chk("count advances", 32'((c2 - c1) >= 20 && (c2 - c1) <= 32), 32'h1);
	endtask : tRuns

	task automatic tOtherCode();
		logic [31:0] c1, c2;
		rdCount(c1);
		wrGuarded(swd_pkg::CODE_OFFSET, 32'h55);
		rdCount(c2);
		chk("other code keeps count", 32'(c2 > c1), 32'h1);
	endtask : tOtherCode

	task automatic tDebug();
		logic [31:0] c1, c2, c3;
		@(posedge clk);
		debugHalt <= 1'b1;
		repeat (4) @(posedge clk);
		rdCount(c1);
		repeat (10) @(posedge clk);
		rdCount(c2);
		chk("frozen in debug", c2, c1);
		debugHalt <= 1'b0;
		repeat (4) @(posedge clk);
		rdCount(c3);
		chk("runs after debug", 32'(c3 > c2), 32'h1);
	endtask : tDebug

	task automatic tInterrupt();
		logic [31:0] c;
		int n;
		n = 0;
		wrGuarded(swd_pkg::CODE_OFFSET, 32'(swd_pkg::CODE_CLEAR));
		do begin
			@(negedge clk);
			n++;
		end while (irq !== 1'b1);
		// clear lands one cycle before the write task returns
		chk("timeout after period 0", 32'(n >= 32760 && n <= 32770), 32'h1);
		chk("pin low with irq", 32'(pinN), 32'h0);
		chk("no reset in irq mode", 32'(rstReq), 32'h0);
		repeat (50) @(negedge clk);
		chk("pin stays low", 32'(pinN), 32'h0);
		wrGuarded(swd_pkg::CODE_OFFSET, 32'(swd_pkg::CODE_CLEAR));
		chk("pin released by clear", 32'(pinN), 32'h1);
		rdCount(c);
		chk("count restarted", 32'(c < 40), 32'h1);
	endtask : tInterrupt

	// code write follows the mode write without polling in between
	task automatic tDisable();
		logic [31:0] c, c0;
		logic [1:0] r;
		wrGuarded(swd_pkg::MODE_OFFSET, 32'h00);
		rdCount(c0);
		rdCount(c);
		chk("enable bit alone keeps counting", 32'(c != c0), 32'h1);
		axiWrite(swd_pkg::CODE_OFFSET, 32'(swd_pkg::CODE_DISABLE), r);
		rdCount(c);
		chk("disabled count", c, 32'h0);
		repeat (50) @(posedge clk);
		rdCount(c);
		chk("disabled stays", c, 32'h0);
		wrGuarded(swd_pkg::MODE_OFFSET, 32'h80);
		rdCount(c);
		chk("re-enabled runs", 32'(c != 0), 32'h1);
	endtask : tDisable

	task automatic tResetAction();
		logic [31:0] v;
		logic [1:0] r;
		int n;
		n = 0;
		wrGuarded(swd_pkg::MODE_OFFSET, 32'h82);
		wrGuarded(swd_pkg::CODE_OFFSET, 32'(swd_pkg::CODE_CLEAR));
		do @(negedge clk); while (rstReq !== 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (rstReq === 1'b1);
		chk("reset hold length", 32'(n), 32'd32);
		axiRead(swd_pkg::MODE_OFFSET, v, r);
		chk("mode after reset", v, 32'(swd_pkg::MODE_RESET));
	endtask : tResetAction

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		fails = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		debugHalt = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		tReset();
		tModes();
		tBusyFlag();
		tRuns();
		tOtherCode();
		tDebug();
		tInterrupt();
		tDisable();
		tResetAction();
		end_of_test();
	end

	// two period-0 timeouts dominate the run; allow ample margin
	initial begin
		#1000000;
		fails++;
		end_of_test();
	end
endmodule : tb_swd_watchdog
